// file: design/ipd_pkg.sv
// in-position detector package: register map, field widths, reset values,
// mode and state encodings and timing constants.
// assumes a 100 MHz control clock and a 32-bit classic wishbone register bus.
package ipd_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] IPD_OFS_RANGE = 8'h00;
  localparam logic [7:0] IPD_OFS_COND = 8'h04;
  localparam logic [7:0] IPD_OFS_HOLD = 8'h08;
  localparam logic [7:0] IPD_OFS_ZSL = 8'h0C;
  localparam logic [7:0] IPD_OFS_UNIT = 8'h10;
  localparam logic [7:0] IPD_OFS_STATUS = 8'h14;
  localparam int IPD_ADR_W = 8;

  // field widths
  localparam int IPD_RANGE_W = 22;
  localparam int IPD_COND_W = 4;
  localparam int IPD_HOLD_W = 15;
  localparam int IPD_ZSL_W = 15;

  // reset values and limits
  localparam logic [21:0] IPD_RANGE_RST = 22'h00000A;
  localparam logic [21:0] IPD_RANGE_MAX = 22'h200000;
  localparam logic [3:0] IPD_COND_RST = 4'h0;
  localparam logic [3:0] IPD_COND_MAX = 4'hA;
  localparam logic [3:0] IPD_COND_SPLIT = 4'h5;
  localparam logic [14:0] IPD_HOLD_RST = 15'h0000;
  localparam logic [14:0] IPD_HOLD_MAX = 15'h7530;
  localparam logic [14:0] IPD_ZSL_RST = 15'h0032;
  localparam logic [14:0] IPD_ZSL_MIN = 15'h000A;
  localparam logic [14:0] IPD_ZSL_MAX = 15'h4E20;
  localparam logic IPD_UNIT_RST = 1'b0;

  // status register bit positions
  localparam int IPD_ST_SETTLED = 0;
  localparam int IPD_ST_ZERO_SPEED = 1;
  localparam int IPD_ST_CMD = 2;
  localparam int IPD_ST_JUDGE = 3;
  localparam int IPD_ST_HOLD_LO = 4;

  // timing: one millisecond in cycles of the control clock
  localparam int IPD_MS_NS = 1000000;
  localparam int IPD_CLK_PERIOD_NS = 10;
  localparam int IPD_CYCLES_PER_MS = IPD_MS_NS / IPD_CLK_PERIOD_NS;

  // qualification modes after folding the filter choice away
  typedef enum logic [2:0] {
    IPD_M_PLAIN = 3'b000,
    IPD_M_NOCMD = 3'b001,
    IPD_M_ZSP = 3'b010,
    IPD_M_HOLD = 3'b011,
    IPD_M_DELAY = 3'b100,
    IPD_M_DELAY_RANGE = 3'b101
  } ipd_mode_t;

  // holding-mode sequence
  typedef enum logic [1:0] {
    IPD_H_ARMED = 2'b00,
    IPD_H_HELD = 2'b01,
    IPD_H_FOLLOW = 2'b10
  } ipd_hold_t;

endpackage : ipd_pkg

// file: design/ipd_timer_if.sv
// carrier between the detector core and its millisecond timer.
// assumes both ends sit on the same control clock.
`timescale 1ns/100ps
`default_nettype none
interface ipd_timer_if;
  import ipd_pkg::*;
  logic ce;
  logic start;
  logic clear;
  logic [IPD_HOLD_W-1:0] duration;
  logic expired;
  logic running;
  modport ctrl (output ce, output start, output clear, output duration,
                input expired, input running);
  modport tmr (input ce, input start, input clear, input duration,
               output expired, output running);
endinterface : ipd_timer_if
`default_nettype wire

// file: design/ipd_ms_timer.sv
// millisecond down-counter used for hold time and judgment delay.
// assumes start and clear are one-cycle pulses from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module ipd_ms_timer
  import ipd_pkg::*;
#(
  parameter int CYCLES_PER_MS = IPD_CYCLES_PER_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and status
  ipd_timer_if.tmr tif
);
  localparam int PRE_W = (CYCLES_PER_MS > 1) ? $clog2(CYCLES_PER_MS) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);

  generate
    if (CYCLES_PER_MS < 1) begin : g_bad_rate
      $error("ipd_ms_timer: CYCLES_PER_MS must be at least 1");
    end
  endgenerate

  logic [PRE_W-1:0] prescale;
  logic [IPD_HOLD_W-1:0] remaining;
  logic running;
  logic expired;

  wire ms_tick = running && (prescale == PRE_LAST);
  wire last_ms = ms_tick && (remaining == IPD_HOLD_W'(1));

  // start wins over clear so a restart in a clearing cycle is never lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale <= '0;
      remaining <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (tif.ce) begin
      if (tif.start) begin
        prescale <= '0;
        remaining <= tif.duration;
        running <= (tif.duration != '0);
        expired <= (tif.duration == '0); // zero delay: done at once
      end else if (tif.clear) begin
        running <= 1'b0;
        expired <= last_ms; // an expiry in the clearing cycle still counts
      end else if (running) begin
        prescale <= ms_tick ? '0 : prescale + PRE_W'(1);
        if (ms_tick) begin
          remaining <= remaining - IPD_HOLD_W'(1);
        end
        if (last_ms) begin
          running <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

  assign tif.expired = expired;
  assign tif.running = running;

endmodule : ipd_ms_timer
`default_nettype wire

// file: design/ipd_top.sv
// in-position detector: qualifies positional deviation into the settled output.
// assumes deviation, command and speed inputs come from logic on clk_i.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ipd_top
  import ipd_pkg::*;
#(
  parameter int DEV_W = 32,
  parameter int SPD_W = 16,
  parameter int CYCLES_PER_MS = IPD_CYCLES_PER_MS
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [IPD_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // position loop
  input wire logic signed [DEV_W-1:0] cmd_deviation_i,
  input wire logic signed [DEV_W-1:0] enc_deviation_i,
  input wire logic cmd_filtered_i,
  input wire logic cmd_raw_i,
  input wire logic signed [SPD_W-1:0] motor_speed_i,
  // to host controller
  output logic position_settled_output_o,
  output logic zero_speed_flag_o
);

  generate
    if (DEV_W < IPD_RANGE_W + 1 || DEV_W > 32) begin : g_bad_dev
      $error("ipd_top: DEV_W must lie between 23 and 32");
    end
    if (SPD_W < 16 || SPD_W > 32) begin : g_bad_spd
      $error("ipd_top: SPD_W must lie between 16 and 32");
    end
    if (CYCLES_PER_MS < 1) begin : g_bad_rate
      $error("ipd_top: CYCLES_PER_MS must be at least 1");
    end
  endgenerate

  // byte-lane merge of write data over an old value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_lanes

  // fold the condition value into a mode
  function automatic ipd_mode_t cond_mode(input logic [3:0] c);
    logic [3:0] b;
    b = (c > IPD_COND_SPLIT) ? c - IPD_COND_SPLIT : c;
    case (b)
      4'h1: cond_mode = IPD_M_NOCMD;
      4'h2: cond_mode = IPD_M_ZSP;
      4'h3: cond_mode = IPD_M_HOLD;
      4'h4: cond_mode = IPD_M_DELAY;
      4'h5: cond_mode = IPD_M_DELAY_RANGE;
      default: cond_mode = IPD_M_PLAIN;
    endcase
  endfunction : cond_mode

  // registers
  // zero-speed level and unit select sit beside the three core settings
  logic [IPD_RANGE_W-1:0] in_position_range;
  logic [IPD_COND_W-1:0] in_position_condition;
  logic [IPD_HOLD_W-1:0] in_position_hold_time;
  logic [IPD_ZSL_W-1:0] zero_speed_level;
  logic position_unit_select;

  // detector state
  logic settled;
  logic zero_speed;
  logic cmd_prev;
  logic judge_on;
  ipd_hold_t hold_state;
  logic ack;
  logic [31:0] rd_data;

  // timer
  // one shared timer serves both the hold time and the judgment delay
  ipd_timer_if tif ();
  ipd_ms_timer #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tif(tif)
  );

  // bus decode; one wait state keeps the read mux off the ack path
  wire wb_req = wb_cyc_i && wb_stb_i && !ack;
  wire wb_wr = wb_req && wb_we_i;
  wire hit_range = (wb_adr_i == IPD_OFS_RANGE);
  wire hit_cond = (wb_adr_i == IPD_OFS_COND);
  wire hit_hold = (wb_adr_i == IPD_OFS_HOLD);
  wire hit_zsl = (wb_adr_i == IPD_OFS_ZSL);
  wire hit_unit = (wb_adr_i == IPD_OFS_UNIT);
  wire hit_status = (wb_adr_i == IPD_OFS_STATUS);

  // merged write values with limits applied
  // a condition above ten is dropped whole, as clamping would pick a mode
  wire [31:0] m_range = merge_lanes({10'h000, in_position_range}, wb_dat_i, wb_sel_i);
  wire [31:0] m_cond = merge_lanes({28'h0000000, in_position_condition}, wb_dat_i, wb_sel_i);
  wire [31:0] m_hold = merge_lanes({17'h00000, in_position_hold_time}, wb_dat_i, wb_sel_i);
  wire [31:0] m_zsl = merge_lanes({17'h00000, zero_speed_level}, wb_dat_i, wb_sel_i);
  wire [31:0] m_unit = merge_lanes({31'h00000000, position_unit_select}, wb_dat_i, wb_sel_i);
  wire [IPD_RANGE_W-1:0] w_range = (m_range > {10'h000, IPD_RANGE_MAX}) ?
      IPD_RANGE_MAX : m_range[IPD_RANGE_W-1:0];
  wire cond_ok = (m_cond <= {28'h0000000, IPD_COND_MAX});
  wire [IPD_HOLD_W-1:0] w_hold = (m_hold > {17'h00000, IPD_HOLD_MAX}) ?
      IPD_HOLD_MAX : m_hold[IPD_HOLD_W-1:0];
  wire [IPD_ZSL_W-1:0] w_zsl = (m_zsl > {17'h00000, IPD_ZSL_MAX}) ? IPD_ZSL_MAX :
      (m_zsl < {17'h00000, IPD_ZSL_MIN}) ? IPD_ZSL_MIN : m_zsl[IPD_ZSL_W-1:0];
  wire cond_wr = wb_wr && hit_cond && cond_ok;

  // register file; an out-of-range condition write is dropped, range, hold and zero-speed level writes clamp
  // byte lanes merge before the clamp, so a partial write lands in range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_position_range <= IPD_RANGE_RST;
      in_position_condition <= IPD_COND_RST;
      in_position_hold_time <= IPD_HOLD_RST;
      zero_speed_level <= IPD_ZSL_RST;
      position_unit_select <= IPD_UNIT_RST;
    end else if (ce_i) begin
      if (wb_wr && hit_range) begin
        in_position_range <= w_range;
      end
      if (cond_wr) begin
        in_position_condition <= m_cond[IPD_COND_W-1:0];
      end
      if (wb_wr && hit_hold) begin
        in_position_hold_time <= w_hold;
      end
      if (wb_wr && hit_zsl) begin
        zero_speed_level <= w_zsl;
      end
      if (wb_wr && hit_unit) begin
        position_unit_select <= m_unit[0];
      end
    end
  end

  // read mux; unmapped offsets read zero and still acknowledge
  // the status word is read only; writes to it ack and are dropped
  logic [31:0] next_rd;
  always_comb begin
    next_rd = 32'h00000000;
    if (hit_range) begin
      next_rd = {10'h000, in_position_range};
    end else if (hit_cond) begin
      next_rd = {28'h0000000, in_position_condition};
    end else if (hit_hold) begin
      next_rd = {17'h00000, in_position_hold_time};
    end else if (hit_zsl) begin
      next_rd = {17'h00000, zero_speed_level};
    end else if (hit_unit) begin
      next_rd = {31'h00000000, position_unit_select};
    end else if (hit_status) begin
      next_rd[IPD_ST_SETTLED] = settled;
      next_rd[IPD_ST_ZERO_SPEED] = zero_speed;
      next_rd[IPD_ST_CMD] = cmd_prev;
      next_rd[IPD_ST_JUDGE] = judge_on;
      next_rd[IPD_ST_HOLD_LO +: 2] = hold_state;
    end
  end

  // ack one cycle after the request, dropped the cycle after
  // ack low gates taking, so a request held through ack is taken once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rd_data <= 32'h00000000;
    end else if (ce_i) begin
      ack <= wb_req;
      if (wb_req && !wb_we_i) begin
        rd_data <= next_rd;
      end
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;

  // deviation and speed magnitudes; the most negative value is held as its
  // unsigned magnitude, so it never wraps to a small number
  // both compares are strict: a value equal to its limit does not count
  wire signed [DEV_W-1:0] dev_sel = position_unit_select ?
      enc_deviation_i : cmd_deviation_i;
  wire [DEV_W-1:0] dev_mag = dev_sel[DEV_W-1] ? DEV_W'(-dev_sel) : DEV_W'(dev_sel);
  wire below = (dev_mag < DEV_W'(in_position_range));
  wire [SPD_W-1:0] spd_mag = motor_speed_i[SPD_W-1] ?
      SPD_W'(-motor_speed_i) : SPD_W'(motor_speed_i);
  wire next_zero_speed = (spd_mag < SPD_W'(zero_speed_level));

  // command source and its falling edge
  // a condition write across 5 and 6 swaps the source without a clean
  // edge; the write re-arms everything, so a false end only starts a timer
  wire cmd_now = (in_position_condition > IPD_COND_SPLIT) ?
      cmd_raw_i : cmd_filtered_i;
  wire cmd_fall = cmd_prev && !cmd_now;
  wire idle_in = !cmd_now && below;
  ipd_mode_t mode;
  assign mode = cond_mode(in_position_condition);

  // qualification per mode
  // one combinational step per mode keeps the output a single flop away
  logic next_settled;
  logic next_judge;
  ipd_hold_t next_hold;
  logic tmr_start;
  logic tmr_clear;
  always_comb begin
    next_settled = 1'b0;
    next_judge = judge_on;
    next_hold = hold_state;
    tmr_start = 1'b0;
    tmr_clear = 1'b0;
    case (mode)
      IPD_M_PLAIN: begin
        next_settled = below;
      end
      IPD_M_NOCMD: begin
        next_settled = idle_in;
      end
      IPD_M_ZSP: begin
        next_settled = idle_in && zero_speed;
      end
      // armed until the first settle, held for a nonzero hold time, then following; a zero hold time holds until a command;
      // a command always re-arms, so the hold never outlives a new move
      IPD_M_HOLD: begin
        case (hold_state)
          IPD_H_ARMED: begin
            next_settled = idle_in;
            if (idle_in) begin
              next_hold = IPD_H_HELD;
              tmr_start = 1'b1;
            end
          end
          IPD_H_HELD: begin
            next_settled = 1'b1;
            if (cmd_now) begin
              next_hold = IPD_H_ARMED;
              next_settled = 1'b0;
              tmr_clear = 1'b1;
            end else if (in_position_hold_time != '0 && tif.expired) begin
              next_hold = IPD_H_FOLLOW;
              next_settled = idle_in;
            end
          end
          IPD_H_FOLLOW: begin
            next_settled = idle_in;
            if (cmd_now) begin
              next_hold = IPD_H_ARMED;
            end
          end
          default: begin
            next_hold = IPD_H_ARMED;
          end
        endcase
      end
      // expiry stays set until a command or condition write clears the timer, so in the range variant a
      // deviation that enters the range late still opens judgment
      IPD_M_DELAY, IPD_M_DELAY_RANGE: begin
        if (cmd_now) begin
          next_judge = 1'b0;
          tmr_clear = 1'b1;
        end else if (cmd_fall) begin
          tmr_start = 1'b1;
        end else if (!judge_on && tif.expired) begin
          next_judge = (mode == IPD_M_DELAY) || below;
        end
        next_settled = judge_on && idle_in;
      end
      default: begin
        next_settled = 1'b0;
      end
    endcase
    // a new condition restarts the sequences from a clean state
    if (cond_wr) begin
      next_hold = IPD_H_ARMED;
      next_judge = 1'b1;
      tmr_clear = 1'b1;
    end
  end

  assign tif.ce = ce_i;
  assign tif.start = tmr_start && !cond_wr;
  assign tif.clear = tmr_clear;
  assign tif.duration = in_position_hold_time;

  // detector state; judging starts enabled so a first move is not needed
  // the host sees settled one cycle after the deviation and command inputs that caused it, two after speed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settled <= 1'b0;
      zero_speed <= 1'b0;
      cmd_prev <= 1'b0;
      judge_on <= 1'b1;
      hold_state <= IPD_H_ARMED;
    end else if (ce_i) begin
      settled <= next_settled;
      zero_speed <= next_zero_speed;
      cmd_prev <= cmd_now;
      judge_on <= next_judge;
      hold_state <= next_hold;
    end
  end

  assign position_settled_output_o = settled;
  assign zero_speed_flag_o = zero_speed;

endmodule : ipd_top
`default_nettype wire

// file: verification/ipd_host_model.sv
// host controller model: samples the settled output once per control cycle.
// assumes the output is a registered level on the detector's own clock.
`timescale 1ns/100ps
`default_nettype none
module ipd_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from the detector
  input wire logic settled_i,
  // what the host last saw
  output logic level_o
);
  // a real host polls slower; sampling every edge catches any one-cycle glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else begin
      level_o <= settled_i;
    end
  end
endmodule : ipd_host_model
`default_nettype wire

// file: verification/ipd_top_assertions.sv
// assertions on the in-position detector top ports, bound into ipd_top.
// assumes full-word writes and the zero-speed level left at its reset value.
`timescale 1ns/100ps
`default_nettype none
module ipd_top_assertions
  import ipd_pkg::*;
#(
  parameter int DEV_W = 32,
  parameter int SPD_W = 16,
  parameter int CYCLES_PER_MS = IPD_CYCLES_PER_MS
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [IPD_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // position loop and outputs
  input wire logic signed [DEV_W-1:0] cmd_deviation_i,
  input wire logic signed [DEV_W-1:0] enc_deviation_i,
  input wire logic cmd_filtered_i,
  input wire logic cmd_raw_i,
  input wire logic signed [SPD_W-1:0] motor_speed_i,
  input wire logic position_settled_output_o,
  input wire logic zero_speed_flag_o
);
  logic [21:0] rng;
  logic [3:0] cnd;
  logic [14:0] hld;
  logic unit;
  logic cwr;
  // decode of taken requests and of the qualifying inputs
  wire logic take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire logic wr_w = take_w && wb_we_i;
  wire logic cmd_w = (cnd > 4'h5) ? cmd_raw_i : cmd_filtered_i;
  wire logic [DEV_W-1:0] dv_w = unit ? enc_deviation_i : cmd_deviation_i;
  wire logic [DEV_W-1:0] mag_w = dv_w[DEV_W-1] ? -dv_w : dv_w;
  wire logic below_w = mag_w < DEV_W'(rng);
  wire logic nc_w = !cmd_w && below_w;
  wire logic [SPD_W-1:0] smag_w = motor_speed_i[SPD_W-1] ? -motor_speed_i : motor_speed_i;
  wire logic zs_w = smag_w < SPD_W'(IPD_ZSL_RST);
  wire logic m_hold = (cnd == 4'h3) || (cnd == 4'h8);
  wire logic m_zsp = (cnd == 4'h2) || (cnd == 4'h7);
  wire logic m_dly = (cnd == 4'h4) || (cnd == 4'h5) || (cnd == 4'h9) || (cnd == 4'hA);
  // register shadow; writes land at the taking edge, as in the design
  always_ff @(posedge clk_i) begin
    cwr <= wr_w && (wb_adr_i == IPD_OFS_COND);
    if (rst_i) begin
      rng <= IPD_RANGE_RST;
      cnd <= IPD_COND_RST;
      hld <= IPD_HOLD_RST;
      unit <= IPD_UNIT_RST;
    end else if (wr_w) begin
      if (wb_adr_i == IPD_OFS_RANGE) begin
        rng <= (wb_dat_i > 32'h00200000) ? IPD_RANGE_MAX : wb_dat_i[21:0];
      end
      if ((wb_adr_i == IPD_OFS_COND) && (wb_dat_i <= 32'h0000000A)) begin
        cnd <= wb_dat_i[3:0];
      end
      if (wb_adr_i == IPD_OFS_HOLD) begin
        hld <= (wb_dat_i > 32'h00007530) ? IPD_HOLD_MAX : wb_dat_i[14:0];
      end
      if (wb_adr_i == IPD_OFS_UNIT) begin
        unit <= wb_dat_i[0];
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_resp;
    take_w |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o && ce_i |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_plain;
    ce_i && (cnd == 4'h0) ##1 ce_i |-> position_settled_output_o == $past(below_w);
  endproperty
  a_plain: assert property (p_plain) else $error("plain mode output wrong");
  property p_nocmd;
    ce_i && (cnd == 4'h1 || cnd == 4'h6) ##1 ce_i |-> position_settled_output_o == $past(nc_w);
  endproperty
  a_nocmd: assert property (p_nocmd) else $error("no-command mode output wrong");
  property p_zsp;
    ce_i && m_zsp ##1 ce_i && position_settled_output_o |-> $past(nc_w && zero_speed_flag_o);
  endproperty
  a_zsp: assert property (p_zsp) else $error("settled without zero speed");
  property p_zflag;
    ce_i ##1 ce_i |-> zero_speed_flag_o == $past(zs_w);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero-speed flag wrong");
  property p_hold0;
    ce_i && m_hold && (hld == 15'h0000) && !cwr && position_settled_output_o && !cmd_w
      |=> position_settled_output_o;
  endproperty
  a_hold0: assert property (p_hold0) else $error("held output dropped");
  property p_cmd_drop;
    ce_i && (cnd != 4'h0) && cmd_w ##1 ce_i |-> !position_settled_output_o;
  endproperty
  a_cmd_drop: assert property (p_cmd_drop) else $error("settled with command present");
  property p_delay;
    m_dly && (hld == 15'h0002) && !cwr && $fell(cmd_w) |-> !position_settled_output_o [*8];
  endproperty
  a_delay: assert property (p_delay) else $error("judgment before delay");
  // main scenarios reached
  c_held: cover property (m_hold && position_settled_output_o);
  c_dly: cover property (m_dly && position_settled_output_o);
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : ipd_top_assertions
bind ipd_top ipd_top_assertions #(
  .DEV_W(DEV_W), .SPD_W(SPD_W), .CYCLES_PER_MS(CYCLES_PER_MS)
) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmd_deviation_i(cmd_deviation_i), .enc_deviation_i(enc_deviation_i),
  .cmd_filtered_i(cmd_filtered_i), .cmd_raw_i(cmd_raw_i), .motor_speed_i(motor_speed_i),
  .position_settled_output_o(position_settled_output_o),
  .zero_speed_flag_o(zero_speed_flag_o)
);
`default_nettype wire

// file: verification/ipd_top_tb.sv
// self-checking bench for the in-position detector with a host model on its output.
// assumes 100 MHz and a millisecond shortened to CPM cycles.
`timescale 1ns/100ps
`default_nettype none
module ipd_top_tb;
  import ipd_pkg::*;
  localparam int CPM = 4;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic signed [31:0] cmd_deviation_i, enc_deviation_i;
  logic signed [15:0] motor_speed_i;
  logic cmd_filtered_i, cmd_raw_i, settled, zsf, level;
  int bad_count, cmp_count;
  ipd_top #(.CYCLES_PER_MS(CPM)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmd_deviation_i(cmd_deviation_i), .enc_deviation_i(enc_deviation_i),
    .cmd_filtered_i(cmd_filtered_i), .cmd_raw_i(cmd_raw_i), .motor_speed_i(motor_speed_i),
    .position_settled_output_o(settled), .zero_speed_flag_o(zsf)
  );
  ipd_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .settled_i(settled), .level_o(level));
  // free-running control clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    check(q, e);
  endtask : rd_chk
  task automatic pos(input logic f, input logic r, input logic [31:0] d, input logic [15:0] s);
    @(posedge clk_i);
    cmd_filtered_i <= f;
    cmd_raw_i <= r;
    cmd_deviation_i <= d;
    motor_speed_i <= s;
  endtask : pos
  // judged through the host, which lags the output by one cycle
  task automatic expect_out(input int n, input logic e);
    repeat (n) @(posedge clk_i);
    #1;
    check({31'h0, level}, {31'h0, e});
  endtask : expect_out
  task automatic t_regs();
    rd_chk(IPD_OFS_RANGE, 32'h0000000A);
    rd_chk(IPD_OFS_COND, 32'h00000000);
    rd_chk(IPD_OFS_HOLD, 32'h00000000);
    rd_chk(8'h18, 32'h00000000);
    wr(IPD_OFS_RANGE, 32'h00300000);
    rd_chk(IPD_OFS_RANGE, 32'h00200000);
    wr(IPD_OFS_HOLD, 32'h00007531);
    rd_chk(IPD_OFS_HOLD, 32'h00007530);
    wr(IPD_OFS_COND, 32'h0000000A);
    wr(IPD_OFS_COND, 32'h0000000B);
    rd_chk(IPD_OFS_COND, 32'h0000000A);
    wr(IPD_OFS_COND, 32'h00000000);
    wr(IPD_OFS_RANGE, 32'h00000020);
    wr(IPD_OFS_HOLD, 32'h00000000);
  endtask : t_regs
  task automatic t_plain();
    pos(1'b1, 1'b1, 32'h00000005, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b1, 1'b1, 32'hFFFFFFFB, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b1, 1'b1, 32'hFFFFFFE0, 16'h0000);
    expect_out(3, 1'b0);
    pos(1'b1, 1'b1, 32'h0000001F, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b1, 1'b1, 32'h00001000, 16'h0000);
    enc_deviation_i <= 32'h00000005;
    expect_out(3, 1'b0);
    wr(IPD_OFS_UNIT, 32'h00000001);
    expect_out(3, 1'b1);
    wr(IPD_OFS_UNIT, 32'h00000000);
    expect_out(3, 1'b0);
  endtask : t_plain
  task automatic t_modes();
    logic [3:0] m [4] = '{4'h1, 4'h6, 4'h2, 4'h7};
    logic raw;
    for (int i = 0; i < 4; i++) begin
      raw = m[i] > 4'h5;
      wr(IPD_OFS_COND, {28'h0, m[i]});
      pos(raw, !raw, 32'h00000003, 16'h0000);
      expect_out(3, 1'b1);
      pos(!raw, raw, 32'h00000003, 16'h0000);
      expect_out(3, 1'b0);
      pos(raw, !raw, 32'h00000003, 16'h0032);
      expect_out(3, !(m[i] == 4'h2 || m[i] == 4'h7));
    end
    pos(1'b1, 1'b1, 32'h00001000, 16'hFFCF);
    expect_out(3, 1'b0);
    check({31'h0, zsf}, 32'h00000001);
    pos(1'b1, 1'b1, 32'h00001000, 16'hFFCE);
    expect_out(3, 1'b0);
    check({31'h0, zsf}, 32'h00000000);
  endtask : t_modes
  task automatic t_hold();
    wr(IPD_OFS_COND, 32'h00000003);
    pos(1'b1, 1'b1, 32'h00000003, 16'h0000);
    expect_out(3, 1'b0);
    pos(1'b0, 1'b0, 32'h00000003, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b0, 1'b0, 32'h00001000, 16'h0000);
    expect_out(12, 1'b1);
    pos(1'b1, 1'b1, 32'h00001000, 16'h0000);
    expect_out(3, 1'b0);
    wr(IPD_OFS_HOLD, 32'h00000002);
    pos(1'b0, 1'b0, 32'h00000003, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b0, 1'b0, 32'h00001000, 16'h0000);
    expect_out(2, 1'b1);
    expect_out(10, 1'b0);
    pos(1'b1, 1'b1, 32'h00000003, 16'h0000);
    expect_out(3, 1'b0);
    pos(1'b0, 1'b0, 32'h00000003, 16'h0000);
    expect_out(3, 1'b1);
    pos(1'b1, 1'b1, 32'h00000003, 16'h0000);
    expect_out(2, 1'b0);
  endtask : t_hold
  task automatic t_delay();
    logic [3:0] m [4] = '{4'h4, 4'h9, 4'h5, 4'hA};
    for (int i = 0; i < 4; i++) begin
      wr(IPD_OFS_COND, {28'h0, m[i]});
      pos(1'b1, 1'b1, 32'h00000003, 16'h0000);
      expect_out(3, 1'b0);
      pos(1'b0, 1'b0, 32'h00000003, 16'h0000);
      expect_out(3, 1'b0);
      expect_out(12, 1'b1);
    end
  endtask : t_delay
  // reset, then the scenarios in turn
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    cmd_deviation_i = 32'h00001000;
    enc_deviation_i = 32'h00001000;
    cmd_filtered_i = 1'b1;
    cmd_raw_i = 1'b1;
    motor_speed_i = 16'h03E8;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_plain();
    t_modes();
    t_hold();
    t_delay();
    conclude();
  end
endmodule : ipd_top_tb
`default_nettype wire
